// [gfs_pkg.sv]
// package: register map, fields and timing for the fault supervisor
package gfs_pkg;
    // register indices on the plain register port
    localparam logic [3:0] ADDR_CTRL     = 4'h0; // amp enable, gain, offset
    localparam logic [3:0] ADDR_CFG      = 4'h1; // thresholds and responses
    localparam logic [3:0] ADDR_SD_CUR   = 4'h2; // shutdown current
    localparam logic [3:0] ADDR_CMD      = 4'h3; // fault clear command
    localparam logic [3:0] ADDR_STATUS   = 4'h4; // latched faults
    localparam logic [3:0] ADDR_RAW      = 4'h5; // latched faults, bits 9:8
    localparam logic [3:0] ADDR_GATE     = 4'h6; // gate state
    // control register fields
    localparam int CTRL_AMP_EN    = 0;
    localparam int CTRL_GAIN_LSB  = 1;
    localparam int CTRL_OFFS      = 5;
    // config register fields
    localparam int CFG_WARN_LVL_LSB = 0;
    localparam int CFG_OV_LVL_LSB   = 2;
    localparam int CFG_GS_UV_RESP   = 4;
    localparam int CFG_BOOT_UV_RESP = 5;
    localparam int CFG_BOOT_UV_LAT  = 6;
    localparam int CFG_WARN_RESP    = 7;
    localparam int CMD_CLEAR        = 0;
    // reset values
    localparam logic [7:0] CTRL_RST   = 8'h00;
    localparam logic [7:0] CFG_RST    = 8'h70;
    localparam logic [7:0] SD_CUR_RST = 8'h08;
    localparam logic [3:0] GAIN_MAX   = 4'h8;
    localparam logic [1:0] OV_LVL_MAX = 2'h2;
    // fault vector positions
    localparam int N_MON       = 10;
    localparam int F_SUP_WARN  = 0;
    localparam int F_SUP_UV    = 1;
    localparam int F_SUP_OV    = 2;
    localparam int F_GS_UV     = 3;
    localparam int F_GS_OV     = 4;
    localparam int F_BOOT_UV   = 5;
    localparam int F_BOOT_OV   = 6;
    localparam int F_PUMP_UV   = 7;
    localparam int F_PUMP_OV   = 8;
    localparam int F_DRAIN_UV  = 9;
    // timing at 25 MHz
    localparam int CLK_NS        = 40;
    localparam int DEGLITCH_NS   = 10000;
    localparam int DEGLITCH_CYC  = DEGLITCH_NS / CLK_NS;
    localparam int SD_FIRST_NS   = 1000;
    localparam int SD_TOTAL_NS   = 4000;
    localparam int SD_FIRST_CYC  = (SD_FIRST_NS + CLK_NS - 1) / CLK_NS;
    localparam int SD_TOTAL_CYC  = (SD_TOTAL_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W         = 9;
    // shutdown sequence states
    typedef enum logic [1:0] {
        GFS_RUN    = 2'b00,
        GFS_INIT   = 2'b01,
        GFS_PROG   = 2'b10,
        GFS_HOLD   = 2'b11
    } gfs_sd_t;
    // pull-down drive levels on the sd_drive output
    localparam logic [1:0] DRV_NONE = 2'h0;
    localparam logic [1:0] DRV_INIT = 2'h1;
    localparam logic [1:0] DRV_PROG = 2'h2;
    localparam logic [1:0] DRV_SEMI = 2'h3;
endpackage

// [gfs_supervisor.sv]
// top: gate driver fault supervisor with register port
//
// The implementer's own choices: the strobed register port and the address map.
`timescale 1ns/10ps
module gfs_supervisor (
    input  wire logic                    clk,
    input  wire logic                    resetn,
    input  wire logic [3:0]              reg_addr,
    input  wire logic [7:0]              reg_wdata,
    input  wire logic                    reg_wr,
    input  wire logic                    reg_rd,
    output logic      [7:0]              reg_rdata,
    input  wire logic [gfs_pkg::N_MON-1:0] mon_raw,
    input  wire logic                    driver_disable_pin,
    input  wire logic [2:0]              high_side_pwm_input,
    input  wire logic [2:0]              low_side_pwm_input,
    output logic [2:0]                   gate_high,
    output logic [2:0]                   gate_low,
    output logic [1:0]                   sd_drive,
    output logic [3:0]                   shutdown_pulldown_current,
    output logic                         pump_enable,
    output logic                         fault_indicator_low,
    output logic                         current_sense_amp_en,
    output logic [3:0]                   current_sense_amp_gain,
    output logic                         current_sense_amp_offs_eighth,
    output logic [1:0]                   supply_warn_threshold_sel,
    output logic [1:0]                   supply_ov_threshold_sel
);
    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [7:0] ctrl_r, ctrl_nxt;
    logic [7:0] cfg_r, cfg_nxt;
    logic [7:0] sdc_r, sdc_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic       clear_cmd;
    logic [gfs_pkg::N_MON-1:0] flt_r, flt_nxt;

    always_comb begin
        ctrl_nxt  = ctrl_r;
        cfg_nxt   = cfg_r;
        sdc_nxt   = sdc_r;
        clear_cmd = 1'b0;
        if (reg_wr) begin
            unique case (reg_addr)
                gfs_pkg::ADDR_CTRL: begin
                    ctrl_nxt = reg_wdata;
                    // gain codes above eight saturate: only nine exist
                    if (reg_wdata[gfs_pkg::CTRL_GAIN_LSB +: 4] > gfs_pkg::GAIN_MAX) begin
                        ctrl_nxt[gfs_pkg::CTRL_GAIN_LSB +: 4] = gfs_pkg::GAIN_MAX;
                    end
                end
                gfs_pkg::ADDR_CFG: begin
                    cfg_nxt = reg_wdata;
                    // code 3 is not a level, keep the highest one
                    if (reg_wdata[gfs_pkg::CFG_OV_LVL_LSB +: 2] > gfs_pkg::OV_LVL_MAX) begin
                        cfg_nxt[gfs_pkg::CFG_OV_LVL_LSB +: 2] = gfs_pkg::OV_LVL_MAX;
                    end
                end
                gfs_pkg::ADDR_SD_CUR: sdc_nxt = reg_wdata;
                gfs_pkg::ADDR_CMD:    clear_cmd = reg_wdata[gfs_pkg::CMD_CLEAR];
                default: ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // deglitch filters, one per monitor
    // ----------------------------------------------------------------
    logic [gfs_pkg::N_MON-1:0] det;
    genvar gi;
    generate
        for (gi = 0; gi < gfs_pkg::N_MON; gi = gi + 1) begin : g_dg
            logic [gfs_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
            logic                      hit_r, hit_nxt;
            always_comb begin
                cnt_nxt = '0;
                hit_nxt = 1'b0;
                if (mon_raw[gi]) begin
                    if (cnt_r == gfs_pkg::CNT_W'(gfs_pkg::DEGLITCH_CYC)) begin
                        cnt_nxt = cnt_r;
                        hit_nxt = 1'b1;
                    end else begin
                        cnt_nxt = cnt_r + 1'b1;
                    end
                end
            end
            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    cnt_r <= '0;
                    hit_r <= 1'b0;
                end else begin
                    cnt_r <= cnt_nxt;
                    hit_r <= hit_nxt;
                end
            end
            assign det[gi] = hit_r;
        end
    endgenerate

    // ----------------------------------------------------------------
    // fault latches
    // ----------------------------------------------------------------
    logic boot_latch;
    always_comb begin
        boot_latch = cfg_r[gfs_pkg::CFG_BOOT_UV_LAT];
        // detection wins over a clear in the same cycle
        flt_nxt = clear_cmd ? det : (flt_r | det);
        // boot uv tracks the live level when latching is off
        if (!boot_latch) begin
            flt_nxt[gfs_pkg::F_BOOT_UV] = det[gfs_pkg::F_BOOT_UV];
        end
        flt_nxt[gfs_pkg::F_SUP_WARN] = clear_cmd ? det[gfs_pkg::F_SUP_WARN]
                                     : (flt_r[gfs_pkg::F_SUP_WARN] | det[gfs_pkg::F_SUP_WARN]);
    end

    // fault terms: hard faults stop driver and pump, boot uv blocks the high side, warning drives the pin
    logic gs_uv_act, boot_uv_act, hard_flt, warn_pin, any_sd;
    always_comb begin
        gs_uv_act   = flt_r[gfs_pkg::F_GS_UV] & cfg_r[gfs_pkg::CFG_GS_UV_RESP];
        boot_uv_act = flt_r[gfs_pkg::F_BOOT_UV] & cfg_r[gfs_pkg::CFG_BOOT_UV_RESP];
        hard_flt    = flt_r[gfs_pkg::F_SUP_UV] | flt_r[gfs_pkg::F_SUP_OV] | gs_uv_act
                    | flt_r[gfs_pkg::F_GS_OV] | flt_r[gfs_pkg::F_BOOT_OV] | flt_r[gfs_pkg::F_PUMP_UV]
                    | flt_r[gfs_pkg::F_PUMP_OV] | flt_r[gfs_pkg::F_DRAIN_UV];
        // warning reaches the pin only when its response bit is set
        warn_pin    = flt_r[gfs_pkg::F_SUP_WARN] & cfg_r[gfs_pkg::CFG_WARN_RESP];
        any_sd      = hard_flt | driver_disable_pin;
    end

    // ----------------------------------------------------------------
    // shutdown sequence
    // ----------------------------------------------------------------
    gfs_pkg::gfs_sd_t          sd_r, sd_nxt;
    logic [gfs_pkg::CNT_W-1:0] sdt_r, sdt_nxt;
    logic [1:0]                drv_nxt;
    always_comb begin
        sd_nxt  = sd_r;
        sdt_nxt = sdt_r;
        unique case (sd_r)
            gfs_pkg::GFS_RUN: begin
                sdt_nxt = '0;
                if (any_sd) begin
                    sd_nxt = gfs_pkg::GFS_INIT;
                end
            end
            gfs_pkg::GFS_INIT: begin
                sdt_nxt = sdt_r + 1'b1;
                if (sdt_r == gfs_pkg::CNT_W'(gfs_pkg::SD_FIRST_CYC - 1)) begin
                    sd_nxt = gfs_pkg::GFS_PROG;
                end
            end
            gfs_pkg::GFS_PROG: begin
                sdt_nxt = sdt_r + 1'b1;
                if (sdt_r == gfs_pkg::CNT_W'(gfs_pkg::SD_TOTAL_CYC - 1)) begin
                    sd_nxt = gfs_pkg::GFS_HOLD;
                end
            end
            gfs_pkg::GFS_HOLD: begin
                // stays parked until every cause is gone
                if (!any_sd) begin
                    sd_nxt = gfs_pkg::GFS_RUN;
                end
            end
        endcase
        unique case (sd_nxt)
            gfs_pkg::GFS_RUN:  drv_nxt = gfs_pkg::DRV_NONE;
            gfs_pkg::GFS_INIT: drv_nxt = gfs_pkg::DRV_INIT;
            gfs_pkg::GFS_PROG: drv_nxt = gfs_pkg::DRV_PROG;
            gfs_pkg::GFS_HOLD: drv_nxt = gfs_pkg::DRV_SEMI;
        endcase
    end

    // ----------------------------------------------------------------
    // gate outputs
    // ----------------------------------------------------------------
    logic [2:0] gh_nxt, gl_nxt;
    always_comb begin
        // pwm stays blocked until the sequence is back in run: never drive
        // a gate on against a pull-down that is still applied
        if (any_sd || sd_nxt != gfs_pkg::GFS_RUN) begin
            // disable pin is combined ahead of the pwm path
            gh_nxt = 3'h0;
            gl_nxt = 3'h0;
        end else begin
            gh_nxt = boot_uv_act ? 3'h0 : high_side_pwm_input;
            gl_nxt = low_side_pwm_input;
        end
    end

    // ----------------------------------------------------------------
    // read data
    // ----------------------------------------------------------------
    always_comb begin
        rdata_nxt = 8'h00;
        if (reg_rd) begin
            unique case (reg_addr)
                gfs_pkg::ADDR_CTRL:   rdata_nxt = ctrl_r;
                gfs_pkg::ADDR_CFG:    rdata_nxt = cfg_r;
                gfs_pkg::ADDR_SD_CUR: rdata_nxt = sdc_r;
                gfs_pkg::ADDR_STATUS: rdata_nxt = flt_r[7:0];
                gfs_pkg::ADDR_RAW:    rdata_nxt = {6'h00, flt_r[gfs_pkg::N_MON-1:8]};
                gfs_pkg::ADDR_GATE:   rdata_nxt = {4'h0, any_sd, hard_flt, sd_r};
                default:              rdata_nxt = 8'h00;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // output next values
    // ----------------------------------------------------------------
    logic       pump_nxt, pin_low_nxt;
    logic       amp_en_nxt, offs_nxt;
    logic [3:0] gain_nxt, sdcur_nxt;
    logic [1:0] warn_sel_nxt, ov_sel_nxt;

    always_comb begin
        // boot uv leaves the pump running, only hard faults stop it
        pump_nxt    = ~hard_flt;
        pin_low_nxt = ~(hard_flt | boot_uv_act | warn_pin);
    end

    always_comb begin
        amp_en_nxt   = ctrl_r[gfs_pkg::CTRL_AMP_EN];
        gain_nxt     = ctrl_r[gfs_pkg::CTRL_GAIN_LSB +: 4];
        offs_nxt     = ctrl_r[gfs_pkg::CTRL_OFFS];
        sdcur_nxt    = sdc_r[3:0];
        warn_sel_nxt = cfg_r[gfs_pkg::CFG_WARN_LVL_LSB +: 2];
        ov_sel_nxt   = cfg_r[gfs_pkg::CFG_OV_LVL_LSB +: 2];
    end

    // ----------------------------------------------------------------
    // register file
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_r <= gfs_pkg::CTRL_RST;
            cfg_r  <= gfs_pkg::CFG_RST;
            sdc_r  <= gfs_pkg::SD_CUR_RST;
        end else begin
            ctrl_r <= ctrl_nxt;
            cfg_r  <= cfg_nxt;
            sdc_r  <= sdc_nxt;
        end
    end

    // ----------------------------------------------------------------
    // fault and sequence state
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            flt_r <= '0;
        end else begin
            flt_r <= flt_nxt;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sd_r  <= gfs_pkg::GFS_RUN;
            sdt_r <= '0;
        end else begin
            sd_r  <= sd_nxt;
            sdt_r <= sdt_nxt;
        end
    end

    // ----------------------------------------------------------------
    // pin outputs, all straight from flops
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            gate_high <= 3'h0;
            gate_low  <= 3'h0;
        end else begin
            gate_high <= gh_nxt;
            gate_low  <= gl_nxt;
        end
    end

    // drive level is decoded from the next state, so it moves with it
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sd_drive <= gfs_pkg::DRV_NONE;
        end else begin
            sd_drive <= drv_nxt;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pump_enable <= 1'b0;
        end else begin
            pump_enable <= pump_nxt;
        end
    end

    // pin idles high, so reset leaves it released
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            fault_indicator_low <= 1'b1;
        end else begin
            fault_indicator_low <= pin_low_nxt;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            current_sense_amp_en          <= 1'b0;
            current_sense_amp_gain        <= 4'h0;
            current_sense_amp_offs_eighth <= 1'b0;
        end else begin
            current_sense_amp_en          <= amp_en_nxt;
            current_sense_amp_gain        <= gain_nxt;
            current_sense_amp_offs_eighth <= offs_nxt;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            shutdown_pulldown_current <= 4'h0;
        end else begin
            shutdown_pulldown_current <= sdcur_nxt;
        end
    end

    // threshold codes only steer the analog comparators
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            supply_warn_threshold_sel <= 2'h0;
        end else begin
            supply_warn_threshold_sel <= warn_sel_nxt;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            supply_ov_threshold_sel <= 2'h0;
        end else begin
            supply_ov_threshold_sel <= ov_sel_nxt;
        end
    end

    // ----------------------------------------------------------------
    // register read port
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    // the port is a plain wire onto the rdata flop
    assign reg_rdata = rdata_r;
endmodule // gfs_supervisor

// [gfs_host.sv]
// partner: host controller model on the register port
`timescale 1ns/10ps
module gfs_host (
    input  wire logic       clk,
    output logic      [3:0] reg_addr = 4'h0,
    output logic      [7:0] reg_wdata = 8'h00,
    output logic            reg_wr = 1'b0,
    output logic            reg_rd = 1'b0,
    input  wire logic [7:0] reg_rdata
);
    // amplifier output is not trusted before this settle span
    localparam int SETTLE_CYC = 100000 / gfs_pkg::CLK_NS;
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
        reg_wdata <= ~d; // no stale data once released
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic clear();
        wr(gfs_pkg::ADDR_CMD, 8'h01);
    endtask
    task automatic amp_on();
        wr(gfs_pkg::ADDR_CTRL, 8'h01);
        repeat (SETTLE_CYC) @(posedge clk);
    endtask
endmodule // gfs_host

// [gfs_supervisor_chk.sv]
// checker: port assertions for the fault supervisor
`timescale 1ns/10ps
module gfs_supervisor_chk (
    input wire logic                      clk,
    input wire logic                      resetn,
    input wire logic [3:0]                reg_addr,
    input wire logic [7:0]                reg_wdata,
    input wire logic                      reg_wr,
    input wire logic [gfs_pkg::N_MON-1:0] mon_raw,
    input wire logic                      driver_disable_pin,
    input wire logic [2:0]                gate_high,
    input wire logic [2:0]                gate_low,
    input wire logic [1:0]                sd_drive,
    input wire logic                      pump_enable,
    input wire logic                      fault_indicator_low,
    input wire logic                      current_sense_amp_en,
    input wire logic [3:0]                current_sense_amp_gain,
    input wire logic [1:0]                supply_ov_threshold_sel
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    logic [8:0] uv_cnt_r, uv_cnt_nxt;
    logic [2:0] clr_win_r, clr_win_nxt;
    logic [3:0] gain_w;
    logic [1:0] ov_w;
    assign gain_w = (reg_wdata[4:1] > gfs_pkg::GAIN_MAX) ? gfs_pkg::GAIN_MAX : reg_wdata[4:1];
    assign ov_w = (reg_wdata[3:2] > gfs_pkg::OV_LVL_MAX) ? gfs_pkg::OV_LVL_MAX : reg_wdata[3:2];
    // pin may only rise a few cycles after a clear write
    always_comb begin
        uv_cnt_nxt = mon_raw[gfs_pkg::F_SUP_UV] ? uv_cnt_r + {8'h00, ~&uv_cnt_r} : 9'h000;
        clr_win_nxt = clr_win_r - {2'h0, |clr_win_r};
        if (reg_wr && reg_addr == gfs_pkg::ADDR_CMD && reg_wdata[0])
            clr_win_nxt = 3'h6;
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            uv_cnt_r  <= 9'h000;
            clr_win_r <= 3'h0;
        end else begin
            uv_cnt_r  <= uv_cnt_nxt;
            clr_win_r <= clr_win_nxt;
        end
    end
    AST_PIN_OFF: assert property (driver_disable_pin [*2] |=> gate_high == 3'h0 && gate_low == 3'h0)
        else $error("gates not off under disable pin");
    AST_PUMP_PIN: assert property ($past(resetn) && !pump_enable |-> !fault_indicator_low)
        else $error("pump off without fault pin");
    AST_SD_INIT: assert property (sd_drive == 2'h1 && $past(sd_drive) == 2'h0 |-> ##25
        sd_drive == gfs_pkg::DRV_PROG) else $error("initial pull-down span wrong");
    AST_SD_PROG: assert property (sd_drive == 2'h2 && $past(sd_drive) == 2'h1 |-> ##75
        sd_drive == gfs_pkg::DRV_SEMI) else $error("programmed pull-down span wrong");
    AST_UV_TRIP: assert property (uv_cnt_r >= 9'h100 |-> !fault_indicator_low && !pump_enable)
        else $error("supply undervoltage not acted on");
    AST_CLR_ONLY: assert property ($rose(fault_indicator_low) |-> clr_win_r != 3'h0)
        else $error("fault pin released without clear");
    AST_AMP: assert property (reg_wr && reg_addr == gfs_pkg::ADDR_CTRL |-> ##2
        current_sense_amp_en == $past(reg_wdata[0], 2) && current_sense_amp_gain == $past(gain_w, 2))
        else $error("amplifier settings wrong");
    AST_OV_SEL: assert property (reg_wr && reg_addr == gfs_pkg::ADDR_CFG |-> ##2
        supply_ov_threshold_sel == $past(ov_w, 2)) else $error("overvoltage level wrong");
    cover property (sd_drive == gfs_pkg::DRV_SEMI);
    cover property (!fault_indicator_low && pump_enable);
    cover property (driver_disable_pin [*2]);
endmodule // gfs_supervisor_chk
bind gfs_supervisor gfs_supervisor_chk u_chk (.clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .mon_raw,
    .driver_disable_pin, .gate_high, .gate_low, .sd_drive, .pump_enable, .fault_indicator_low,
    .current_sense_amp_en, .current_sense_amp_gain, .supply_ov_threshold_sel);

// [test_gfs_supervisor.sv]
// testbench: random and corner stimulus for the fault supervisor
`timescale 1ns/10ps
module test_gfs_supervisor;
    logic                      clk, resetn, driver_disable_pin, reg_wr, reg_rd, pump_enable;
    logic                      fault_indicator_low, current_sense_amp_en, current_sense_amp_offs_eighth;
    logic [1:0]                sd_drive, supply_warn_threshold_sel, supply_ov_threshold_sel;
    logic [2:0]                high_side_pwm_input, low_side_pwm_input, gate_high, gate_low;
    logic [3:0]                reg_addr, shutdown_pulldown_current, current_sense_amp_gain;
    logic [7:0]                reg_wdata, reg_rdata, v, x;
    logic [gfs_pkg::N_MON-1:0] mon_raw, m;
    int                        fail_count, cmp_count, seed, i;
    gfs_supervisor dut (.clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .mon_raw,
        .driver_disable_pin, .high_side_pwm_input, .low_side_pwm_input, .gate_high, .gate_low, .sd_drive,
        .shutdown_pulldown_current, .pump_enable, .fault_indicator_low, .current_sense_amp_en,
        .current_sense_amp_gain, .current_sense_amp_offs_eighth, .supply_warn_threshold_sel,
        .supply_ov_threshold_sel);
    gfs_host host (.clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
    function automatic logic [7:0] clamp(input logic [3:0] val, input logic [3:0] top);
        return 8'((val > top) ? top : val);
    endfunction
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s: expected %h, seen %h", nm, exp, seen);
        end
    endtask
    task automatic rchk(input logic [3:0] a, input logic [7:0] msk, input logic [7:0] exp);
        host.rd(a, x);
        check("register", x & msk, exp);
    endtask
    task automatic raise(input logic [gfs_pkg::N_MON-1:0] r, input int n);
        @(posedge clk) mon_raw <= r;
        cyc(n);
    endtask
    task automatic test_done();
        $display("comparisons %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        #(40 * 20000);
        fail_count++;
        test_done();
    end
    initial begin
        {seed, fail_count, cmp_count} = {32'd17, 64'd0};
        {resetn, driver_disable_pin, high_side_pwm_input, low_side_pwm_input} = 8'h00;
        mon_raw = '0;
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        rchk(gfs_pkg::ADDR_CTRL, 8'hFF, gfs_pkg::CTRL_RST);
        check("amp_en", 8'(current_sense_amp_en), 8'h00);
        rchk(gfs_pkg::ADDR_CFG, 8'hFF, gfs_pkg::CFG_RST);
        rchk(gfs_pkg::ADDR_SD_CUR, 8'hFF, gfs_pkg::SD_CUR_RST);
        rchk(4'hF, 8'hFF, 8'h00);
        for (i = 0; i < 10; i++) begin
            v = (8'($random(seed)) & 8'h21) | 8'(i << 1);
            host.wr(gfs_pkg::ADDR_CTRL, v);
            cyc(1);
            check("gain", 8'(current_sense_amp_gain), clamp(v[4:1], gfs_pkg::GAIN_MAX));
            check("offset", 8'(current_sense_amp_offs_eighth), 8'(v[5]));
            check("amp_en", 8'(current_sense_amp_en), 8'(v[0]));
        end
        for (i = 0; i < 8; i++) begin
            v = 8'($random(seed));
            v[3:2] = 2'(i);
            host.wr(gfs_pkg::ADDR_CFG, v);
            cyc(1);
            check("warn_lvl", 8'(supply_warn_threshold_sel), 8'(v[1:0]));
            check("ov_lvl", 8'(supply_ov_threshold_sel), clamp(4'(v[3:2]), 4'(gfs_pkg::OV_LVL_MAX)));
        end
        host.wr(gfs_pkg::ADDR_CFG, gfs_pkg::CFG_RST);
        v = 8'($random(seed));
        host.wr(gfs_pkg::ADDR_SD_CUR, v);
        cyc(1);
        check("sd_cur", 8'(shutdown_pulldown_current), 8'(v[3:0]));
        host.amp_on();
        @(posedge clk) {high_side_pwm_input, low_side_pwm_input} <= 6'b101010;
        cyc(4);
        check("gate_high", 8'(gate_high), 8'h05);
        @(posedge clk) driver_disable_pin <= 1'b1;
        cyc(3);
        check("gates", {2'h0, gate_high, gate_low}, 8'h00);
        check("sd", 8'(sd_drive), 8'(gfs_pkg::DRV_INIT));
        cyc(30);
        check("sd", 8'(sd_drive), 8'(gfs_pkg::DRV_PROG));
        cyc(80);
        check("sd", 8'(sd_drive), 8'(gfs_pkg::DRV_SEMI));
        rchk(gfs_pkg::ADDR_GATE, 8'h0F, {4'h0, 1'b1, 1'b0, 2'(gfs_pkg::GFS_HOLD)});
        @(posedge clk) driver_disable_pin <= 1'b0;
        cyc(4);
        check("sd", {4'h0, sd_drive, gate_low[1], gate_high[0]}, 8'h03);
        // every monitor but the warning, one at a time
        for (i = 1; i < gfs_pkg::N_MON; i++) begin
            m = '0;
            m[i] = 1'b1;
            raise(m, 260);
            check("pin", 8'(fault_indicator_low), 8'h00);
            check("pump", 8'(pump_enable), 8'(i == gfs_pkg::F_BOOT_UV));
            check("gl", 8'(gate_low), (i == gfs_pkg::F_BOOT_UV) ? 8'h02 : 8'h00);
            check("gh", 8'(gate_high), 8'h00);
            raise('0, 5);
            check("held", 8'(fault_indicator_low), 8'h00);
            if (i < 8)
                rchk(gfs_pkg::ADDR_STATUS, 8'h01 << i, 8'h01 << i);
            else
                rchk(gfs_pkg::ADDR_RAW, 8'h03, 8'h01 << (i - 8));
            host.clear();
            cyc(5);
            check("freed", 8'(fault_indicator_low), 8'h01);
            rchk(gfs_pkg::ADDR_STATUS, 8'hFF, 8'h00);
        end
        // warning and gate-supply undervoltage with pin response off
        host.wr(gfs_pkg::ADDR_CFG, 8'h60);
        raise(10'h009, 260);
        check("pin", 8'(fault_indicator_low), 8'h01);
        rchk(gfs_pkg::ADDR_STATUS, 8'h09, 8'h09);
        host.wr(gfs_pkg::ADDR_CFG, 8'hE0);
        cyc(3);
        check("warn_pin", 8'(fault_indicator_low), 8'h00);
        raise('0, 2);
        host.clear();
        host.wr(gfs_pkg::ADDR_CFG, gfs_pkg::CFG_RST);
        cyc(5);
        check("freed", 8'(fault_indicator_low), 8'h01);
        // a one-cycle dip restarts the deglitch count
        raise(10'h002, 200);
        raise('0, 0);
        raise(10'h002, 200);
        raise('0, 0);
        rchk(gfs_pkg::ADDR_STATUS, 8'h02, 8'h00);
        check("pin", 8'(fault_indicator_low), 8'h01);
        test_done();
    end
endmodule // test_gfs_supervisor
